// ===== hw/pmwrc_pkg.sv
// Constants for the power mode, wake and reset control block
package pmwrc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_BOD     = 8'h08;
  localparam logic [7:0] OFF_START   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h14;
  localparam logic [7:0] OFF_RETAIN0 = 8'h20;
  localparam logic [7:0] OFF_RETAIN3 = 8'h2C;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLKSEL_LSB = 2;
  localparam int CTRL_KEEP_WDOSC = 4;
  localparam int CTRL_KEEP_BOD = 5;
  localparam int CTRL_ENTER = 8;

  // Brownout register fields
  localparam int BOD_INT_LSB = 0;
  localparam int BOD_RST_LSB = 4;
  localparam int BOD_RST_EN = 7;

  // Interrupt status bit positions
  localparam int IRQ_BOD = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_RESET = 2;
  localparam int IRQ_W = 3;

  // Reset cause bit positions in the status register
  localparam int ST_CAUSE_LSB = 8;

  localparam int START_PINS = 12;
  localparam int RETAIN_REGS = 4;
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;

  // Internal RC start-up and flash init time after reset, in ns
  localparam int INIT_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock restore time after a deep-sleep wake, in ns
  localparam int RESTORE_TIME_NS = 400;
  localparam int RESTORE_CYCLES = (RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] CLK_IRC = 2'h0;

  typedef enum logic [1:0] {
    PMWRC_MODE_SLEEP = 2'b00,
    PMWRC_MODE_DEEP  = 2'b01,
    PMWRC_MODE_DPD   = 2'b10,
    PMWRC_MODE_RSVD  = 2'b11
  } pmwrc_mode_t;

  typedef enum logic [2:0] {
    PMWRC_ST_INIT    = 3'b000,
    PMWRC_ST_RUN     = 3'b001,
    PMWRC_ST_SLEEP   = 3'b010,
    PMWRC_ST_DEEP    = 3'b011,
    PMWRC_ST_RESTORE = 3'b100,
    PMWRC_ST_DPD     = 3'b101
  } pmwrc_state_t;
endpackage

// ===== hw/pmwrc_top.sv
// Power mode sequencer, wake logic, reset collection and brownout control
`timescale 1ns/1ps
module pmwrc_top #(
  parameter int START_PINS = pmwrc_pkg::START_PINS
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  reset_pin_n,
  input  wire logic                  watchdog_timer_reset,
  input  wire logic                  por_event,
  input  wire logic [3:0]            brownout_detector_level,
  input  wire logic [START_PINS-1:0] start_pins,
  input  wire logic                  rtc_match,
  input  wire logic                  power_down_wake_pin_n,
  input  wire logic                  sleep_request,
  input  wire logic                  core_irq_pending,
  output logic                       chip_reset,
  output logic                       flash_init,
  output logic                       irc_enable,
  output logic [1:0]                 sysclk_sel,
  output logic [31:0]                boot_fetch_addr,
  output logic                       core_halt,
  output logic                       core_clk_en,
  output logic                       analog_enable,
  output logic                       wdosc_enable,
  output logic                       brownout_detector_enable,
  output logic                       main_power_enable,
  output logic [START_PINS-1:0]      start_irq,
  output logic                       brownout_irq,
  output logic                       irq
);
  // Two-flop synchronisers for all pin and analog inputs
  localparam int SW = START_PINS + 9;
  logic [SW-1:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {~reset_pin_n, watchdog_timer_reset, por_event, brownout_detector_level,
                    start_pins, rtc_match, ~power_down_wake_pin_n};
      sync2_reg <= sync1_reg;
    end
  end
  logic                  s_pin_rst, s_wdt, s_por, s_rtc, s_wake;
  logic [3:0]            s_bod;
  logic [START_PINS-1:0] s_start;
  assign {s_pin_rst, s_wdt, s_por, s_bod, s_start, s_rtc, s_wake} = sync2_reg;

  // Register state
  logic [31:0] ctrl_reg, ctrl_next;
  logic [7:0]  bod_reg, bod_next;
  logic [START_PINS-1:0] start_en_reg, start_en_next, start_prev_reg, start_prev_next;
  logic [pmwrc_pkg::IRQ_W-1:0] irq_st_reg, irq_st_next, irq_msk_reg, irq_msk_next;
  logic [3:0]  cause_reg, cause_next;
  logic [31:0] retain_reg [pmwrc_pkg::RETAIN_REGS];
  logic [31:0] retain_next [pmwrc_pkg::RETAIN_REGS];
  logic        aphase_reg, aphase_next, awr_reg, awr_next;
  logic [7:0]  aaddr_reg, aaddr_next;
  logic [31:0] hrdata_next;
  pmwrc_pkg::pmwrc_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        bod_rst_hit, any_rst, wake_deep, wake_dpd, start_edge_any;
  logic [START_PINS-1:0] start_edge;

  function automatic logic level_below(input logic [3:0] lvl, input logic [1:0] sel);
    return lvl[sel];
  endfunction

  assign bod_rst_hit = bod_reg[pmwrc_pkg::BOD_RST_EN] &&
                       level_below(s_bod, bod_reg[pmwrc_pkg::BOD_RST_LSB +: 2]);
  assign any_rst = s_pin_rst | s_wdt | s_por | bod_rst_hit;
  // Rising edges of the enabled start pins
  assign start_edge = s_start & ~start_prev_reg & start_en_reg;
  assign start_edge_any = |start_edge;
  // Deep-sleep and power-down have different wake sets
  assign wake_deep = start_edge_any | s_rtc;
  assign wake_dpd = s_wake | s_rtc;

  // Sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      pmwrc_pkg::PMWRC_ST_INIT: begin
        if (any_rst) begin
          cnt_next = '0;
        end else if (cnt_reg == 16'(pmwrc_pkg::INIT_CYCLES - 1)) begin
          state_next = pmwrc_pkg::PMWRC_ST_RUN;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      pmwrc_pkg::PMWRC_ST_RUN: begin
        if (ctrl_reg[pmwrc_pkg::CTRL_ENTER] && sleep_request) begin
          unique case (ctrl_reg[pmwrc_pkg::CTRL_MODE_LSB +: 2])
            pmwrc_pkg::PMWRC_MODE_DEEP: state_next = pmwrc_pkg::PMWRC_ST_DEEP;
            pmwrc_pkg::PMWRC_MODE_DPD:  state_next = pmwrc_pkg::PMWRC_ST_DPD;
            default:                    state_next = pmwrc_pkg::PMWRC_ST_SLEEP;
          endcase
        end
      end
      pmwrc_pkg::PMWRC_ST_SLEEP: begin
        if (core_irq_pending || |irq_st_reg) begin
          state_next = pmwrc_pkg::PMWRC_ST_RUN;
        end
      end
      pmwrc_pkg::PMWRC_ST_DEEP: begin
        if (wake_deep) begin
          state_next = pmwrc_pkg::PMWRC_ST_RESTORE;
          cnt_next = '0;
        end
      end
      pmwrc_pkg::PMWRC_ST_RESTORE: begin
        if (cnt_reg == 16'(pmwrc_pkg::RESTORE_CYCLES - 1)) begin
          state_next = pmwrc_pkg::PMWRC_ST_RUN;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      pmwrc_pkg::PMWRC_ST_DPD: begin
        if (wake_dpd) begin
          state_next = pmwrc_pkg::PMWRC_ST_INIT;
          cnt_next = '0;
        end
      end
      default: state_next = pmwrc_pkg::PMWRC_ST_INIT;
    endcase
    if (any_rst) begin
      state_next = pmwrc_pkg::PMWRC_ST_INIT;
      cnt_next = '0;
    end
  end

  // Bus slave and registers
  always_comb begin
    logic rd_st;
    rd_st = 1'b0;
    ctrl_next = ctrl_reg;
    bod_next = bod_reg;
    start_en_next = start_en_reg;
    start_prev_next = s_start;
    irq_msk_next = irq_msk_reg;
    cause_next = cause_reg;
    hrdata_next = hrdata;
    aphase_next = hsel && hready && htrans[1];
    awr_next = hwrite;
    aaddr_next = haddr[7:0];
    for (int i = 0; i < pmwrc_pkg::RETAIN_REGS; i++) retain_next[i] = retain_reg[i];
    if (aphase_reg && awr_reg) begin
      unique case (aaddr_reg)
        pmwrc_pkg::OFF_CTRL:    ctrl_next = hwdata;
        pmwrc_pkg::OFF_BOD:     bod_next = hwdata[7:0];
        pmwrc_pkg::OFF_START:   start_en_next = hwdata[START_PINS-1:0];
        pmwrc_pkg::OFF_IRQ_MSK: irq_msk_next = hwdata[pmwrc_pkg::IRQ_W-1:0];
        default: begin
          if (aaddr_reg >= pmwrc_pkg::OFF_RETAIN0 && aaddr_reg <= pmwrc_pkg::OFF_RETAIN3)
            retain_next[aaddr_reg[3:2]] = hwdata;
        end
      endcase
    end
    if (aphase_next && !hwrite) begin
      unique case (haddr[7:0])
        pmwrc_pkg::OFF_CTRL:    hrdata_next = ctrl_reg;
        pmwrc_pkg::OFF_STATUS:  hrdata_next = {20'h00000, cause_reg, 3'h0, s_bod[0],
                                               1'b0, state_reg};
        pmwrc_pkg::OFF_BOD:     hrdata_next = {24'h000000, bod_reg};
        pmwrc_pkg::OFF_START:   hrdata_next = 32'(start_en_reg);
        pmwrc_pkg::OFF_IRQ_ST: begin
          hrdata_next = 32'(irq_st_reg);
          rd_st = 1'b1;
        end
        pmwrc_pkg::OFF_IRQ_MSK: hrdata_next = 32'(irq_msk_reg);
        default: begin
          if (haddr[7:0] >= pmwrc_pkg::OFF_RETAIN0 && haddr[7:0] <= pmwrc_pkg::OFF_RETAIN3)
            hrdata_next = retain_reg[haddr[3:2]];
          else
            hrdata_next = 32'h0000_0000;
        end
      endcase
    end
    // Read clears; a new event in the same cycle wins
    irq_st_next = (rd_st ? '0 : irq_st_reg) | {state_reg == pmwrc_pkg::PMWRC_ST_INIT,
                  wake_deep && state_reg == pmwrc_pkg::PMWRC_ST_DEEP,
                  level_below(s_bod, bod_reg[pmwrc_pkg::BOD_INT_LSB +: 2])};
    if (state_reg == pmwrc_pkg::PMWRC_ST_DPD && wake_dpd) begin
      // Power returns: control, brownout, start enable and mask registers clear; retention words, cause and interrupt status keep their contents
      ctrl_next = '0;
      bod_next = '0;
      start_en_next = '0;
      irq_msk_next = '0;
    end
    if (any_rst) begin
      cause_next = {s_pin_rst, s_wdt, s_por, bod_rst_hit};
      ctrl_next = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pmwrc_pkg::PMWRC_ST_INIT;
      cnt_reg <= '0;
      ctrl_reg <= '0;
      bod_reg <= '0;
      start_en_reg <= '0;
      start_prev_reg <= '0;
      irq_st_reg <= '0;
      irq_msk_reg <= '0;
      cause_reg <= '0;
      aphase_reg <= 1'b0;
      awr_reg <= 1'b0;
      aaddr_reg <= '0;
      hrdata <= '0;
      for (int i = 0; i < pmwrc_pkg::RETAIN_REGS; i++) retain_reg[i] <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ctrl_reg <= ctrl_next;
      bod_reg <= bod_next;
      start_en_reg <= start_en_next;
      start_prev_reg <= start_prev_next;
      irq_st_reg <= irq_st_next;
      irq_msk_reg <= irq_msk_next;
      cause_reg <= cause_next;
      aphase_reg <= aphase_next;
      awr_reg <= awr_next;
      aaddr_reg <= aaddr_next;
      hrdata <= hrdata_next;
      for (int i = 0; i < pmwrc_pkg::RETAIN_REGS; i++) retain_reg[i] <= retain_next[i];
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      chip_reset <= 1'b1;
      flash_init <= 1'b1;
      irc_enable <= 1'b1;
      sysclk_sel <= pmwrc_pkg::CLK_IRC;
      boot_fetch_addr <= pmwrc_pkg::RESET_VECTOR;
      core_halt <= 1'b1;
      core_clk_en <= 1'b0;
      analog_enable <= 1'b1;
      wdosc_enable <= 1'b1;
      brownout_detector_enable <= 1'b1;
      main_power_enable <= 1'b1;
      start_irq <= '0;
      brownout_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      chip_reset <= state_next == pmwrc_pkg::PMWRC_ST_INIT;
      flash_init <= state_next == pmwrc_pkg::PMWRC_ST_INIT;
      // The RC oscillator is one of the analog blocks that Deep-sleep stops
      irc_enable <= state_next != pmwrc_pkg::PMWRC_ST_DPD &&
                    state_next != pmwrc_pkg::PMWRC_ST_DEEP;
      sysclk_sel <= ctrl_next[pmwrc_pkg::CTRL_CLKSEL_LSB +: 2];
      boot_fetch_addr <= pmwrc_pkg::RESET_VECTOR;
      core_halt <= state_next != pmwrc_pkg::PMWRC_ST_RUN;
      core_clk_en <= state_next == pmwrc_pkg::PMWRC_ST_RUN;
      analog_enable <= state_next != pmwrc_pkg::PMWRC_ST_DEEP &&
                       state_next != pmwrc_pkg::PMWRC_ST_DPD;
      wdosc_enable <= state_next != pmwrc_pkg::PMWRC_ST_DPD &&
                      (state_next != pmwrc_pkg::PMWRC_ST_DEEP ||
                       ctrl_next[pmwrc_pkg::CTRL_KEEP_WDOSC]);
      brownout_detector_enable <= state_next != pmwrc_pkg::PMWRC_ST_DPD &&
                                  (state_next != pmwrc_pkg::PMWRC_ST_DEEP ||
                                   ctrl_next[pmwrc_pkg::CTRL_KEEP_BOD]);
      main_power_enable <= state_next != pmwrc_pkg::PMWRC_ST_DPD;
      start_irq <= start_edge;
      brownout_irq <= irq_st_next[pmwrc_pkg::IRQ_BOD];
      irq <= |(irq_st_next & irq_msk_next);
    end
  end
endmodule

// ===== tb/pmwrc_props.sv
// Checker of reset, power mode and wake relations at the block's ports
`timescale 1ns/1ps
module pmwrc_props #(
  parameter int START_PINS = 12
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  watchdog_timer_reset,
  input wire logic                  rtc_match,
  input wire logic                  power_down_wake_pin_n,
  input wire logic                  chip_reset,
  input wire logic                  flash_init,
  input wire logic                  irc_enable,
  input wire logic [1:0]            sysclk_sel,
  input wire logic [31:0]           boot_fetch_addr,
  input wire logic                  core_halt,
  input wire logic                  core_clk_en,
  input wire logic                  analog_enable,
  input wire logic                  wdosc_enable,
  input wire logic                  brownout_detector_enable,
  input wire logic                  main_power_enable,
  input wire logic [START_PINS-1:0] start_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wdt_reset; watchdog_timer_reset |-> ##[1:5] chip_reset; endproperty
  property p_init; chip_reset |-> flash_init && irc_enable; endproperty
  property p_irc_sel; $fell(chip_reset) |-> sysclk_sel == 2'h0; endproperty
  property p_boot; $fell(chip_reset) |-> boot_fetch_addr == 32'h0000_0000; endproperty
  property p_halt; core_halt |-> !core_clk_en; endproperty
  property p_deep; !analog_enable |-> core_halt; endproperty
  property p_dpd_off;
    !main_power_enable |-> !analog_enable && !wdosc_enable && !brownout_detector_enable;
  endproperty
  property p_dpd_hold;
    (!main_power_enable && power_down_wake_pin_n && !rtc_match) [*6] |=> !main_power_enable;
  endproperty
  property p_pulse; start_irq[0] |=> !start_irq[0]; endproperty
  property p_restore; core_clk_en |-> irc_enable; endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("no chip reset on watchdog");
  a_init: assert property (p_init) else $error("reset without flash init or RC");
  a_irc_sel: assert property (p_irc_sel) else $error("clock not RC after reset");
  a_boot: assert property (p_boot) else $error("boot address not zero");
  a_halt: assert property (p_halt) else $error("core clocked while halted");
  a_deep: assert property (p_deep) else $error("analog off while core runs");
  a_dpd_off: assert property (p_dpd_off) else $error("block powered in power-down");
  a_dpd_hold: assert property (p_dpd_hold) else $error("power-down left without wake");
  a_pulse: assert property (p_pulse) else $error("start interrupt longer than pulse");
  a_restore: assert property (p_restore) else $error("core resumed without RC");
  c_dpd: cover property (!main_power_enable);
  c_deep: cover property ($fell(analog_enable) && main_power_enable);
  c_start: cover property (|start_irq);
endmodule
bind pmwrc_top pmwrc_props #(.START_PINS(START_PINS)) pmwrc_props_i (
  .clk(clk), .rst_n(rst_n), .watchdog_timer_reset(watchdog_timer_reset),
  .rtc_match(rtc_match), .power_down_wake_pin_n(power_down_wake_pin_n),
  .chip_reset(chip_reset), .flash_init(flash_init), .irc_enable(irc_enable),
  .sysclk_sel(sysclk_sel), .boot_fetch_addr(boot_fetch_addr), .core_halt(core_halt),
  .core_clk_en(core_clk_en), .analog_enable(analog_enable), .wdosc_enable(wdosc_enable),
  .brownout_detector_enable(brownout_detector_enable),
  .main_power_enable(main_power_enable), .start_irq(start_irq));

// ===== tb/pmwrc_core_model.sv
// Behavioural processor core and interrupt controller facing the block
`timescale 1ns/1ps
module pmwrc_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go_sleep,
  input  wire logic        irq_req,
  input  wire logic        core_clk_en,
  input  wire logic [11:0] start_irq,
  output logic             sleep_request,
  output logic             core_irq_pending
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_request <= 1'b0;
      core_irq_pending <= 1'b0;
    end else begin
      // The sleep instruction only executes while the core is clocked
      sleep_request <= go_sleep && core_clk_en;
      // Pending stays until the running core services it
      core_irq_pending <= irq_req || (|start_irq) || (core_irq_pending && !core_clk_en);
    end
  end
endmodule

// ===== tb/tb_power_mode_wake_reset_control.sv
// Self-checking testbench of the power mode, wake and reset block
`timescale 1ns/1ps
module tb_power_mode_wake_reset_control;
  logic        clk = 1'b0;
  logic        rst_n, hsel, hwrite, reset_pin_n, wdt, por, rtc, wake_n, go_sleep, irq_req;
  logic        hreadyout, hresp, sreq, pend, chip_reset, flash_init, irc_en, halt, clk_en;
  logic        ana_en, wdo_en, bod_en, mpe, bod_irq, irq;
  logic [1:0]  htrans, sysclk_sel;
  logic [2:0]  hsize;
  logic [3:0]  bod_lvl;
  logic [11:0] pins, start_irq, seen;
  logic [31:0] haddr, hwdata, hrdata, boot, d;
  int          err_count, checked, n, k;
  // Byte offset, written word, expected read
  localparam logic [7:0]  RA [7] = '{8'h00, 8'h08, 8'h0C, 8'h14, 8'h20, 8'h2C, 8'h40};
  localparam logic [31:0] RW [7] = '{32'h3C, 32'h33, 32'hFFF, 32'h7, 32'hA5A5_5A5A,
                                     32'h1234_5678, 32'hFFFF_FFFF};
  localparam logic [31:0] RE [7] = '{32'h3C, 32'h33, 32'hFFF, 32'h7, 32'hA5A5_5A5A,
                                     32'h1234_5678, 32'h0};
  always #10 clk = ~clk;
  pmwrc_top pmwrc_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reset_pin_n(reset_pin_n),
    .watchdog_timer_reset(wdt), .por_event(por), .brownout_detector_level(bod_lvl),
    .start_pins(pins), .rtc_match(rtc), .power_down_wake_pin_n(wake_n),
    .sleep_request(sreq), .core_irq_pending(pend), .chip_reset(chip_reset),
    .flash_init(flash_init), .irc_enable(irc_en), .sysclk_sel(sysclk_sel),
    .boot_fetch_addr(boot), .core_halt(halt), .core_clk_en(clk_en), .analog_enable(ana_en),
    .wdosc_enable(wdo_en), .brownout_detector_enable(bod_en), .main_power_enable(mpe),
    .start_irq(start_irq), .brownout_irq(bod_irq), .irq(irq));
  pmwrc_core_model pmwrc_core_model_i (.clk(clk), .rst_n(rst_n), .go_sleep(go_sleep),
    .irq_req(irq_req), .core_clk_en(clk_en), .start_irq(start_irq), .sleep_request(sreq),
    .core_irq_pending(pend));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    d = hrdata;
    chk({30'h0, hreadyout, hresp}, 32'h2);
  endtask
  task automatic finish_test;
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic enter(input logic [31:0] ctrl);
    bus(1'b1, pmwrc_pkg::OFF_CTRL, ctrl);
    go_sleep <= 1'b1;
    for (n = 0; n < 20 && halt !== 1'b1; n++) @(posedge clk);
    go_sleep <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    {rst_n, hsel, hwrite, wdt, por, rtc, go_sleep, irq_req} = '0;
    {reset_pin_n, wake_n} = 2'h3;
    {haddr, hwdata, htrans, bod_lvl, pins} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({29'h0, chip_reset, flash_init, irc_en}, 32'h7);
    for (n = 0; n < 300 && chip_reset !== 1'b0; n++) @(posedge clk);
    chk({31'h0, n == pmwrc_pkg::INIT_CYCLES}, 32'h1);
    chk({30'h0, sysclk_sel}, 32'h0);
    chk(boot, 32'h0);
    for (k = 0; k < 7; k++) begin
      bus(1'b1, RA[k], RW[k]);
      bus(1'b0, RA[k], 32'h0);
      chk(d, RE[k]);
    end
    chk({30'h0, sysclk_sel}, 32'h3);
    bus(1'b1, pmwrc_pkg::OFF_CTRL, 32'h0);
    bus(1'b0, pmwrc_pkg::OFF_IRQ_ST, 32'h0);
    enter(32'h100);
    chk({29'h0, halt, clk_en, ana_en}, 32'h5);
    irq_req <= 1'b1;
    for (n = 0; n < 20 && clk_en !== 1'b1; n++) @(posedge clk);
    irq_req <= 1'b0;
    chk({31'h0, halt}, 32'h0);
    bus(1'b1, pmwrc_pkg::OFF_START, 32'h1);
    for (k = 0; k < 2; k++) begin
      enter((k == 0) ? 32'h101 : 32'h131);
      chk({28'h0, irc_en, ana_en, wdo_en, bod_en}, (k == 0) ? 32'h0 : 32'h3);
      pins[0] <= (k == 0);
      rtc <= (k == 1);
      for (n = 0; n < 100 && clk_en !== 1'b1; n++) @(posedge clk);
      chk({31'h0, n >= pmwrc_pkg::RESTORE_CYCLES}, 32'h1);
      pins <= 12'h000;
      rtc <= 1'b0;
      bus(1'b0, pmwrc_pkg::OFF_IRQ_ST, 32'h0);
      chk(d & 32'h2, 32'h2);
      bus(1'b1, pmwrc_pkg::OFF_CTRL, 32'h0);
    end
    bus(1'b1, pmwrc_pkg::OFF_START, 32'hFFF);
    for (k = 0; k < 12; k++) begin
      pins <= 12'h001 << k;
      seen = 12'h000;
      repeat (6) begin
        @(posedge clk);
        seen = seen | start_irq;
      end
      pins <= 12'h000;
      chk({20'h0, seen}, 32'h1 << k);
      repeat (3) @(posedge clk);
    end
    bus(1'b1, pmwrc_pkg::OFF_BOD, 32'h0);
    for (k = 0; k < 2; k++) begin
      bod_lvl <= 4'h1;
      repeat (6) @(posedge clk);
      chk({30'h0, bod_irq, irq}, (k == 0) ? 32'h3 : 32'h2);
      bus(1'b1, pmwrc_pkg::OFF_IRQ_MSK, 32'h0);
      bod_lvl <= 4'h0;
      repeat (4) @(posedge clk);
      bus(1'b0, pmwrc_pkg::OFF_IRQ_ST, 32'h0);
      chk(d & 32'h1, 32'h1);
      repeat (2) @(posedge clk);
      chk({30'h0, bod_irq, irq}, 32'h0);
    end
    for (k = 0; k < 4; k++) begin
      bus(1'b1, pmwrc_pkg::OFF_BOD, 32'h90);
      bus(1'b1, pmwrc_pkg::OFF_CTRL, 32'hC);
      reset_pin_n <= (k != 0);
      wdt <= (k == 1);
      por <= (k == 2);
      bod_lvl <= (k == 3) ? 4'h2 : 4'h0;
      for (n = 0; n < 10 && chip_reset !== 1'b1; n++) @(posedge clk);
      chk({31'h0, chip_reset}, 32'h1);
      {reset_pin_n, wdt, por, bod_lvl} <= 7'h40;
      for (n = 0; n < 300 && chip_reset !== 1'b0; n++) @(posedge clk);
      chk({30'h0, sysclk_sel}, 32'h0);
      bus(1'b0, pmwrc_pkg::OFF_STATUS, 32'h0);
      chk({31'h0, d[11 - k]}, 32'h1);
    end
    bus(1'b1, pmwrc_pkg::OFF_RETAIN0, 32'h5A5A_A5A5);
    enter(32'h10E);
    repeat (10) @(posedge clk);
    chk({29'h0, mpe, ana_en, halt}, 32'h1);
    wake_n <= 1'b0;
    for (n = 0; n < 10 && chip_reset !== 1'b1; n++) @(posedge clk);
    wake_n <= 1'b1;
    chk({31'h0, chip_reset}, 32'h1);
    for (n = 0; n < 300 && chip_reset !== 1'b0; n++) @(posedge clk);
    bus(1'b0, pmwrc_pkg::OFF_RETAIN0, 32'h0);
    chk(d, 32'h5A5A_A5A5);
    chk({30'h0, sysclk_sel}, 32'h0);
    bus(1'b0, pmwrc_pkg::OFF_CTRL, 32'h0);
    chk(d, 32'h0);
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test;
  end
endmodule
